// ===== rtl/spifc_defs.vh
`ifndef SPIFC_DEFS_VH
`define SPIFC_DEFS_VH

// Register byte addresses (word aligned)
`define SPIFC_ADDR_MODE 4'h0
`define SPIFC_ADDR_FMT 4'h4
`define SPIFC_ADDR_DATA 4'h8
`define SPIFC_ADDR_I2C 4'hC

// Mode control fields
`define SPIFC_MODE_ICF 0
`define SPIFC_MODE_EN 1
`define SPIFC_MODE_UMD 4
`define SPIFC_MODE_SIM_LO 5
`define SPIFC_MODE_RESET 8'hE0

// Format control fields
`define SPIFC_FMT_TRF 0
`define SPIFC_FMT_WRITE_COLLISION_FLAG 1
`define SPIFC_FMT_SELECT_PIN_ENABLE 2
`define SPIFC_FMT_MLS 3
`define SPIFC_FMT_CAPTURE_EDGE_SELECT 4
`define SPIFC_FMT_CKPOL 5
`define SPIFC_FMT_RESET 8'h00

// Operating mode codes
`define SPIFC_SIM_SLAVE 3'h5
`define SPIFC_SIM_I2C 3'h6

// I2C control/flag register fields
`define SPIFC_I2C_HTX 0
`define SPIFC_I2C_I2C_ACK_SEND_CONTROL 1
`define SPIFC_I2C_FLAGS_LO 2
`define SPIFC_I2C_FLAG_RESET 5'h00

// Master divider reload; SCK half period is one clock longer
`define SPIFC_HALF_PERIOD 8'h04

`endif

// ===== rtl/spifc_shifter.v
`timescale 1ns/1ps
`default_nettype none
module spifc_shifter (
  input wire clock_in,
  input wire arst_n_in,
  input wire load_in,
  input wire [7:0] load_data_in,
  input wire msb_first_in,
  input wire capture_in,
  input wire launch_in,
  input wire sdi_in,
  output reg sdo_out,
  output reg [7:0] data_out
);
  reg [7:0] sh_reg;
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_reg <= 8'h00;
      sdo_out <= 1'b0;
      data_out <= 8'h00;
    end else if (load_in) begin
      sh_reg <= load_data_in;
      sdo_out <= msb_first_in ? load_data_in[7] : load_data_in[0];
    end else begin
      // Shift on capture, present on launch: works whichever edge comes first
      if (capture_in) begin
        if (msb_first_in) begin
          sh_reg <= {sh_reg[6:0], sdi_in};
          data_out <= {sh_reg[6:0], sdi_in};
        end else begin
          sh_reg <= {sdi_in, sh_reg[7:1]};
          data_out <= {sdi_in, sh_reg[7:1]};
        end
      end
      if (launch_in) begin
        sdo_out <= msb_first_in ? sh_reg[7] : sh_reg[0];
      end
    end
  end
endmodule // spifc_shifter
`default_nettype wire

// ===== rtl/spifc_sync.v
`timescale 1ns/1ps
`default_nettype none
module spifc_sync (
  input wire clock_in,
  input wire arst_n_in,
  input wire async_in,
  output reg level_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change counts only once two stages agree
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // spifc_sync
`default_nettype wire

// ===== rtl/spifc_top.v
// Notes on behaviour
// - Enable low releases SCK, SDO and select pins; logic idles.
// - Enable rising keeps all SPI control register contents.
// - In I2C mode enable rising clears status flags, keeps control bits.
// - Incomplete flag at mode bit 0, active only as SPI slave.
// - Slave select rising mid-transfer sets incomplete and done together.
// - Incomplete condition raises serial interrupt when enabled.
// - Software writing 1 to incomplete flag does not set done.
// - Format bits 7 and 6 are plain read/write storage, reset zero.
// - Clock polarity 0 idles SCK high, 1 idles it low.
// - Polarity 0: edge bit 0 captures on rise, 1 on fall.
// - Polarity 1: edge bit 0 captures on fall, 1 on rise.
// - Shift order 0 is LSB first, 1 is MSB first.
// - Format control register resets to all zero.
// - Select pin used only when select enable is set.
// - Data write during transfer ignored, sets collision flag.
// - Done flag set by hardware, cleared only by software.
// - Master: data write starts transfer; slave follows external clock.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "spifc_defs.vh"
module spifc_top (
  input wire clock_in,
  input wire arst_n_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe_out,
  input wire sdi_in,
  output reg sdo_out,
  output reg sdo_oe_out,
  input wire select_n_in,
  output reg select_n_out,
  output reg select_oe_out,
  input wire i2c_done_evt_in,
  output reg irq_out
);
  reg [7:0] mode_reg;
  reg [7:0] fmt_reg;
  reg [4:0] i2c_flags_reg;
  reg [1:0] i2c_ctl_reg;
  reg en_d_reg;
  reg busy_reg;
  reg [3:0] edges_reg;
  reg [7:0] div_reg;
  reg sck_int_reg;
  reg sck_s_d_reg;
  reg ack_pending_reg;
  wire sck_s;
  wire sel_s;
  wire shift_sdo;
  wire [7:0] shift_data;
  wire en = mode_reg[`SPIFC_MODE_EN];
  wire [2:0] sim = mode_reg[7:`SPIFC_MODE_SIM_LO];
  wire spi_mode = ~mode_reg[`SPIFC_MODE_UMD] && (sim < `SPIFC_SIM_SLAVE);
  wire slave_mode = ~mode_reg[`SPIFC_MODE_UMD] && (sim == `SPIFC_SIM_SLAVE);
  wire i2c_mode = ~mode_reg[`SPIFC_MODE_UMD] && (sim == `SPIFC_SIM_I2C);
  wire ckpol = fmt_reg[`SPIFC_FMT_CKPOL];
  wire capture_edge_select = fmt_reg[`SPIFC_FMT_CAPTURE_EDGE_SELECT];
  wire select_pin_enable = fmt_reg[`SPIFC_FMT_SELECT_PIN_ENABLE];
  // Capture on rise when polarity equals edge select
  wire cap_on_rise = (ckpol == capture_edge_select);
  wire acc = avs_read_in | avs_write_in;
  wire wr_hit = avs_write_in & ack_pending_reg;
  wire rd_hit = avs_read_in & ack_pending_reg;
  wire wr_mode = wr_hit && (avs_address_in == `SPIFC_ADDR_MODE);
  wire wr_fmt = wr_hit && (avs_address_in == `SPIFC_ADDR_FMT);
  wire wr_data = wr_hit && (avs_address_in == `SPIFC_ADDR_DATA);
  wire wr_i2c = wr_hit && (avs_address_in == `SPIFC_ADDR_I2C);
  wire slave_sel = ~select_pin_enable | ~sel_s;
  wire slave_act = en & slave_mode & slave_sel;
  // Slave edge detection on synchronised SCK
  wire s_rise = sck_s & ~sck_s_d_reg;
  wire s_fall = ~sck_s & sck_s_d_reg;
  wire m_tick = en & spi_mode & busy_reg & (div_reg == 8'h00);
  wire m_rise = m_tick & ~sck_int_reg;
  wire m_fall = m_tick & sck_int_reg;
  wire any_rise = slave_act ? s_rise : m_rise;
  wire any_fall = slave_act ? s_fall : m_fall;
  wire cap = cap_on_rise ? any_rise : any_fall;
  wire lau = cap_on_rise ? any_fall : any_rise;
  wire bit_done = cap & busy_reg;
  // Master ends on the edge back to idle, so the last clock pulse is never cut
  wire m_back = m_tick & (sck_int_reg == ckpol);
  wire m_end = m_back & ((edges_reg == 4'h8) | (cap & (edges_reg == 4'h7)));
  wire s_end = bit_done & (edges_reg == 4'h7);
  wire last_bit = slave_act ? s_end : m_end;
  wire start_ok = wr_data & en & ~busy_reg & (spi_mode | slave_mode);
  // Slave released mid-byte
  wire incomplete = en & slave_mode & select_pin_enable & sel_s & busy_reg & (edges_reg != 4'h0);
  wire en_rise = en & ~en_d_reg;

  spifc_sync u_sync_sck (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .async_in(sck_in),
    .level_out(sck_s)
  );

  spifc_sync u_sync_sel (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .async_in(select_n_in),
    .level_out(sel_s)
  );

  spifc_shifter u_shift (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .load_in(start_ok),
    .load_data_in(avs_writedata_in[7:0]),
    .msb_first_in(fmt_reg[`SPIFC_FMT_MLS]),
    .capture_in(bit_done),
    .launch_in(lau & busy_reg),
    .sdi_in(sdi_in),
    .sdo_out(shift_sdo),
    .data_out(shift_data)
  );

  // Bus slave: one wait cycle, then answer
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_pending_reg <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack_pending_reg <= acc & ~ack_pending_reg;
      avs_waitrequest_out <= ~(acc & ~ack_pending_reg);
      if (acc & ~ack_pending_reg & avs_read_in) begin
        case (avs_address_in)
          `SPIFC_ADDR_MODE: avs_readdata_out <= {24'h000000, mode_reg};
          `SPIFC_ADDR_FMT: avs_readdata_out <= {24'h000000, fmt_reg};
          `SPIFC_ADDR_DATA: avs_readdata_out <= {24'h000000, shift_data};
          `SPIFC_ADDR_I2C: avs_readdata_out <= {25'h0000000, i2c_flags_reg, i2c_ctl_reg};
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Control registers and flags
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= `SPIFC_MODE_RESET;
      fmt_reg <= `SPIFC_FMT_RESET;
      i2c_flags_reg <= `SPIFC_I2C_FLAG_RESET;
      i2c_ctl_reg <= 2'h0;
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
      if (wr_mode) begin
        mode_reg <= avs_writedata_in[7:0];
      end
      if (incomplete | ~slave_mode) begin
        mode_reg[`SPIFC_MODE_ICF] <= incomplete ? 1'b1 : 1'b0;
      end
      if (wr_fmt) begin
        fmt_reg <= avs_writedata_in[7:0];
      end
      if (wr_data & busy_reg) begin
        fmt_reg[`SPIFC_FMT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (last_bit | incomplete) begin
        fmt_reg[`SPIFC_FMT_TRF] <= 1'b1;
      end
      if (wr_i2c) begin
        i2c_ctl_reg <= avs_writedata_in[1:0];
        i2c_flags_reg <= avs_writedata_in[6:2];
      end
      if (i2c_mode & i2c_done_evt_in) begin
        i2c_flags_reg[0] <= 1'b1;
      end
      if (i2c_mode & en_rise) begin
        i2c_flags_reg <= `SPIFC_I2C_FLAG_RESET;
      end
    end
  end

  // Transfer engine; enable rise leaves control untouched
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_reg <= 1'b0;
      edges_reg <= 4'h0;
      div_reg <= 8'h00;
      // Idle high as the reset format asks, so no false edge after reset
      sck_int_reg <= 1'b1;
      sck_s_d_reg <= 1'b0;
    end else begin
      sck_s_d_reg <= sck_s;
      if (~en) begin
        busy_reg <= 1'b0;
        edges_reg <= 4'h0;
        sck_int_reg <= ~ckpol;
      end else if (start_ok) begin
        busy_reg <= 1'b1;
        edges_reg <= 4'h0;
        div_reg <= `SPIFC_HALF_PERIOD;
        sck_int_reg <= ~ckpol;
      end else if (incomplete | last_bit) begin
        busy_reg <= 1'b0;
        edges_reg <= 4'h0;
        sck_int_reg <= ~ckpol;
      end else begin
        if (bit_done) begin
          edges_reg <= edges_reg + 4'h1;
        end
        if (~busy_reg) begin
          sck_int_reg <= ~ckpol;
        end else if (spi_mode) begin
          div_reg <= (div_reg == 8'h00) ? `SPIFC_HALF_PERIOD : div_reg - 8'h01;
          if (m_tick) begin
            sck_int_reg <= ~sck_int_reg;
          end
        end
      end
    end
  end

  // Pin drivers
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sck_out <= 1'b1;
      sck_oe_out <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      select_n_out <= 1'b1;
      select_oe_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      sck_out <= sck_int_reg;
      sck_oe_out <= en & spi_mode;
      sdo_out <= shift_sdo;
      sdo_oe_out <= en & (spi_mode | slave_act);
      select_n_out <= ~busy_reg;
      select_oe_out <= en & spi_mode & select_pin_enable;
      irq_out <= (last_bit | incomplete) & mode_reg[`SPIFC_MODE_EN];
    end
  end
endmodule // spifc_top
`default_nettype wire

// ===== tb/spifc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spifc_checker (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic sdo_oe_out,
  input wire logic select_n_out,
  input wire logic select_oe_out,
  input wire logic irq_out
);
  logic [7:0] mode_reg, fmt_reg;
  wire wr_done = avs_write_in && !avs_waitrequest_out;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= 8'hE0;
      fmt_reg <= 8'h00;
    end else if (wr_done && avs_address_in == 4'h0) begin
      mode_reg <= avs_writedata_in[7:0];
    end else if (wr_done && avs_address_in == 4'h4) begin
      fmt_reg <= avs_writedata_in[7:0];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  sequence req_s;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence ack_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  access_answer_a: assert property (req_s |-> ##[1:2] ack_s) else $error("access not answered");
  upper_zero_a: assert property (avs_read_in && !avs_waitrequest_out |->
    avs_readdata_out[31:8] == 24'h0) else $error("read data upper bits set");
  unmapped_read_a: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  irq_pulse_a: assert property (irq_out |=> !irq_out) else $error("irq too long");
  pins_released_a: assert property (!mode_reg[1] ##1 !mode_reg[1] |->
    !sck_oe_out && !sdo_oe_out && !select_oe_out) else $error("pins driven while off");
  select_frame_a: assert property ($rose(irq_out) && select_oe_out |->
    !select_n_out ##1 select_n_out) else $error("select not framing transfer");
  select_unused_a: assert property (!fmt_reg[2] ##1 !fmt_reg[2] |->
    !select_oe_out) else $error("select driven while unused");
  sck_idle_a: assert property ($rose(irq_out) && sck_oe_out |=>
    sck_out == !fmt_reg[5]) else $error("clock not idle after transfer");
  sck_half_a: assert property (sck_oe_out && $changed(sck_out) &&
    $past(fmt_reg, 2) == fmt_reg |=> $stable(sck_out) [*4]) else $error("clock half short");
endmodule // spifc_checker
bind spifc_top spifc_checker chk (.clock_in, .arst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .sck_out,
  .sck_oe_out, .sdo_oe_out, .select_n_out, .select_oe_out, .irq_out);
`default_nettype wire

// ===== tb/spifc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module spifc_partner (
  input wire logic sck_in,
  input wire logic sdo_in,
  input wire logic clr_in,
  input wire logic [7:0] fmt_in,
  input wire logic [7:0] tx_in,
  output logic sdi_out,
  output logic [7:0] rx_out
);
  logic [3:0] cnt = 4'h0, idx = 4'h0;
  wire cap_lvl = (fmt_in[5] == fmt_in[4]);
  wire sdi_bit = tx_in[fmt_in[3] ? 3'h7 - idx[2:0] : idx[2:0]];
  // Line is stale after the last bit, so show the inverse
  assign sdi_out = (cnt == 4'h8) ? !sdi_bit : sdi_bit;
  always @(posedge clr_in) begin
    cnt = 4'h0;
    idx = 4'h0;
  end
  always @(sck_in) begin
    if (!clr_in && sck_in === cap_lvl) begin
      rx_out = fmt_in[3] ? {rx_out[6:0], sdo_in} : {sdo_in, rx_out[7:1]};
      cnt = cnt + 4'h1;
    end else if (!clr_in) begin
      idx = cnt;
    end
  end
endmodule // spifc_partner
`default_nettype wire

// ===== tb/tb_spi_enable_and_format_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_enable_and_format_control;
  logic clock_in = 1'b0, arst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic sck_in = 1'b1, select_n_in = 1'b1, i2c_done_evt_in = 1'b0, clr = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [7:0] fmt = 8'h00, tx = 8'h00, stx = 8'h00, rd, prx;
  logic avs_waitrequest_out, sck_out, sck_oe_out, sdi_in, sdo_out, sdo_oe_out;
  logic select_n_out, select_oe_out, irq_out;
  int bad_count = 0, checked = 0, i;
  logic [23:0] rows [4] = '{24'h00A53C, 24'h1081E7, 24'h28C35A, 24'h3C0180};
  spifc_top uut (.clock_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .sck_in, .sck_out, .sck_oe_out,
    .sdi_in, .sdo_out, .sdo_oe_out, .select_n_in, .select_n_out, .select_oe_out,
    .i2c_done_evt_in, .irq_out);
  spifc_partner far (.sck_in(sck_out), .sdo_in(sdo_out), .clr_in(clr), .fmt_in(fmt),
    .tx_in(stx), .sdi_out(sdi_in), .rx_out(prx));
  always #2.5 clock_in = ~clock_in;
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_read_in <= !w;
    avs_write_in <= w;
    for (n = 0; n < 50 && avs_waitrequest_out !== 1'b0; n++) @(posedge clock_in);
    // First pass samples the edge that raised the request, so retest from n = 1 with no clock step first
    if (n == 0) for (n = 1; n < 50 && avs_waitrequest_out !== 1'b0; n++) @(posedge clock_in);
    if (n == 50) chk("bus answer", 8'h01, 8'h00);
    if (n == 50) summarize;
    rd = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 400 && irq_out !== 1'b1; n++) @(posedge clock_in);
    if (n == 400) chk("irq", 8'h01, 8'h00);
    if (n == 400) summarize;
  endtask
  task automatic frame(input logic [7:0] f, input logic [7:0] d);
    fmt = f;
    bus(1'b1, 4'h4, f);
    clr <= 1'b1;
    // Hold clear past the idle level change that a polarity write causes
    repeat (4) @(posedge clock_in);
    clr <= 1'b0;
    bus(1'b1, 4'h8, d);
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    arst_n_in <= 1'b1;
    bus(1'b1, 4'h0, 8'h02);
    for (i = 0; i < 4; i++) begin
      {fmt, tx, stx} = rows[i];
      frame(fmt, tx);
      wait_irq;
      bus(1'b0, 4'h4, 8'h00); chk("done flag", fmt | 8'h01, rd);
      bus(1'b0, 4'h8, 8'h00); chk("received byte", stx, rd);
      chk("sent byte", tx, prx);
      $display("row %0d done", i);
    end
    frame(8'h38, 8'h11);
    bus(1'b1, 4'h8, 8'h22);
    bus(1'b0, 4'h4, 8'h00); chk("collision flag", 8'h3A, rd);
    wait_irq;
    chk("sent byte", 8'h11, prx);
    $display("collision done");
    bus(1'b1, 4'h0, 8'h00);
    repeat (3) @(posedge clock_in);
    chk("pin enables", 8'h00, {5'h0, sck_oe_out, sdo_oe_out, select_oe_out});
    bus(1'b1, 4'h0, 8'h03); bus(1'b0, 4'h4, 8'h00); chk("format kept", 8'h3B, rd);
    bus(1'b0, 4'h0, 8'h00); chk("flag outside slave", 8'h02, rd);
    bus(1'b1, 4'h4, 8'hC0); bus(1'b0, 4'h4, 8'h00); chk("spare bits", 8'hC0, rd);
    $display("enable done");
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("reset pins", 8'h30, {2'h0, select_n_out, sck_out, sck_oe_out, sdo_oe_out,
      select_oe_out, irq_out});
    arst_n_in <= 1'b1;
    bus(1'b0, 4'h4, 8'h00); chk("format reset", 8'h00, rd);
    bus(1'b0, 4'h0, 8'h00); chk("mode reset", 8'hE0, rd);
    bus(1'b0, 4'h1, 8'h00); chk("unmapped read", 8'h00, rd);
    bus(1'b1, 4'hC, 8'h7F); bus(1'b1, 4'h0, 8'hC0); bus(1'b1, 4'h0, 8'hC2);
    bus(1'b0, 4'hC, 8'h00); chk("i2c after enable", 8'h03, rd);
    i2c_done_evt_in <= 1'b1;
    @(posedge clock_in);
    i2c_done_evt_in <= 1'b0;
    bus(1'b0, 4'hC, 8'h00); chk("i2c done flag", 8'h07, rd);
    $display("i2c done");
    bus(1'b1, 4'h4, 8'h04); bus(1'b1, 4'h0, 8'hA2);
    bus(1'b1, 4'h8, 8'h5A);
    select_n_in <= 1'b0;
    repeat (6) #32 sck_in = ~sck_in;
    @(posedge clock_in);
    select_n_in <= 1'b1;
    wait_irq;
    bus(1'b0, 4'h0, 8'h00); chk("incomplete flag", 8'hA3, rd);
    bus(1'b0, 4'h4, 8'h00); chk("done with incomplete", 8'h05, rd);
    bus(1'b1, 4'h0, 8'hA2); bus(1'b0, 4'h4, 8'h00); chk("done kept", 8'h05, rd);
    bus(1'b1, 4'h4, 8'h04); bus(1'b1, 4'h0, 8'hA3);
    bus(1'b0, 4'h4, 8'h00); chk("done untouched", 8'h04, rd);
    bus(1'b0, 4'h0, 8'h00); chk("flag by software", 8'hA3, rd);
    $display("slave done");
    summarize;
  end
endmodule // tb_spi_enable_and_format_control
`default_nettype wire
